//--- rtl/mrivc_pkg.sv
// Purpose: Shared constants and carriers for the flash read / image verify command handler
// Assumes: 250 MHz single clock, byte-wide flash image held inside the handler
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave

package mrivc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned INSTALL_TIME_S = 8;
  localparam logic [31:0] INSTALL_CYCLES = 32'(64'(INSTALL_TIME_S) * 64'(CLK_HZ));

  // ************************************************************
  // Command and reply codes
  // ************************************************************
  localparam logic [7:0] CMD_READ = 8'h04;
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_VERIFY_INSTALL = 8'h06;
  localparam logic [7:0] RSP_READ = 8'h84;
  localparam logic [7:0] RSP_VERIFY = 8'h85;
  localparam logic [7:0] RSP_VERIFY_INSTALL = 8'h86;
  localparam int unsigned STAT_ERR_BIT = 0;

  // ************************************************************
  // Flash geometry
  // ************************************************************
  localparam int unsigned NUM_BLOCKS = 4;
  localparam int unsigned BLOCK_SIZE = 128;
  localparam int unsigned MEM_BYTES = NUM_BLOCKS * BLOCK_SIZE;
  localparam int unsigned MEM_AW = 9;
  localparam logic [7:0] BLANK_BYTE = 8'hff;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOAD_ADDR = 8'h08;
  localparam logic [7:0] REG_LOAD_DATA = 8'h0c;
  localparam logic [7:0] REG_CMD_COUNT = 8'h10;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int unsigned STS_BUSY_BIT = 0;
  localparam int unsigned STS_INSTALL_BIT = 1;
  localparam int unsigned STS_IMG_VALID_BIT = 2;
  localparam int unsigned STS_IMG_KNOWN_BIT = 3;

  // ************************************************************
  // Frame carriers
  // ************************************************************
  typedef struct packed {
    logic unicast;
    logic [7:0] src_ep;
    logic [7:0] dst_ep;
    logic [7:0] command_code_field;
    logic [7:0] options_field;
    logic [15:0] block_index_field;
    logic [15:0] byte_offset_field;
    logic [15:0] byte_count_field;
  } mrivc_req_t;

  typedef struct packed {
    logic [7:0] dst_ep;
    logic [7:0] src_ep;
    logic [7:0] command_code_field;
    logic [7:0] result_flags_field;
    logic [15:0] block_index_field;
    logic [15:0] byte_offset_field;
    logic [15:0] byte_count_field;
  } mrivc_rsp_t;

endpackage

//--- rtl/mrivc_img_check.sv
// Purpose: Walks the whole flash image and decides whether it is a valid update image
// Assumes: Combinational byte read from the owner's array, one byte per cycle
// Notes:   Valid means byte sum is zero modulo 256 and the first byte is not blank

`timescale 1ns/10ps
`default_nettype none

module mrivc_img_check (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] rd_data_i,
  output logic [mrivc_pkg::MEM_AW-1:0] rd_addr_o,
  output logic done_o,
  output logic valid_o
);

  logic busy_reg, busy_next;
  logic [mrivc_pkg::MEM_AW-1:0] addr_reg, addr_next;
  logic [7:0] sum_reg, sum_next;
  logic blank_reg, blank_next;
  logic done_reg, done_next;
  logic valid_reg, valid_next;
  logic [7:0] sum_now;

  always_comb begin
    busy_next = busy_reg;
    addr_next = addr_reg;
    sum_next = sum_reg;
    blank_next = blank_reg;
    done_next = 1'b0;
    valid_next = valid_reg;
    sum_now = sum_reg + rd_data_i;
    if (start_i) begin
      busy_next = 1'b1;
      addr_next = '0;
      sum_next = 8'h00;
      blank_next = 1'b0;
    end else if (busy_reg) begin
      sum_next = sum_now;
      if (addr_reg == '0) begin
        blank_next = (rd_data_i == mrivc_pkg::BLANK_BYTE);
      end
      if (addr_reg == mrivc_pkg::MEM_AW'(mrivc_pkg::MEM_BYTES - 1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        valid_next = (sum_now == 8'h00) && !blank_reg;
      end else begin
        addr_next = addr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      addr_reg <= '0;
      sum_reg <= 8'h00;
      blank_reg <= 1'b0;
      done_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      addr_reg <= addr_next;
      sum_reg <= sum_next;
      blank_reg <= blank_next;
      done_reg <= done_next;
      valid_reg <= valid_next;
    end
  end

  assign rd_addr_o = addr_reg;
  assign done_o = done_reg;
  assign valid_o = valid_reg;

endmodule // mrivc_img_check

`default_nettype wire

//--- rtl/mrivc_cmd.sv
// Purpose: Command handler for flash read and firmware image verify / install frames
// Assumes: Frames arrive whole on a valid/ready port from logic on the same clock
// Notes:   Flash contents are loaded over the Avalon-MM slave before reads or checks

`timescale 1ns/10ps
`default_nettype none

module mrivc_cmd #(
  parameter logic [31:0] INSTALL_CYCLES = mrivc_pkg::INSTALL_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic req_valid_i,
  input wire mrivc_pkg::mrivc_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output mrivc_pkg::mrivc_rsp_t rsp_o,
  input wire logic rsp_ready_i,
  output logic pay_valid_o,
  output logic [7:0] pay_data_o,
  output logic pay_last_o,
  input wire logic pay_ready_i,
  output logic install_reset_o
);

  typedef enum {ST_IDLE, ST_VERIFY, ST_REPLY, ST_STREAM, ST_INSTALL} mrivc_state_t;

  // ************************************************************
  // Flash image storage
  // ************************************************************
  logic [7:0] mem [mrivc_pkg::MEM_BYTES];
  logic [mrivc_pkg::MEM_AW-1:0] chk_addr;
  logic chk_done, chk_valid;

  // ************************************************************
  // Register bus slave
  // ************************************************************
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic enable_reg, enable_next;
  logic [mrivc_pkg::MEM_AW-1:0] load_addr_reg, load_addr_next;
  logic [15:0] cmd_cnt_reg, cmd_cnt_next;
  logic bus_req, mem_we, lane0;

  // Command engine state, declared early for the status read
  mrivc_state_t state_reg, state_next;
  logic img_valid_reg, img_valid_next;
  logic img_known_reg, img_known_next;

  assign bus_req = avs_read_i || avs_write_i;
  assign lane0 = avs_byteenable_i[0];
  // One wait cycle gives every access a fixed two-cycle answer
  assign avs_waitrequest_o = bus_req && !ack_reg;
  assign mem_we = avs_write_i && ack_reg && lane0 && (avs_address_i == mrivc_pkg::REG_LOAD_DATA);

  always_comb begin
    ack_next = bus_req && !ack_reg;
    rdata_next = rdata_reg;
    enable_next = enable_reg;
    load_addr_next = load_addr_reg;
    if (avs_write_i && ack_reg && lane0) begin
      if (avs_address_i == mrivc_pkg::REG_CTRL) begin
        enable_next = avs_writedata_i[mrivc_pkg::CTRL_ENABLE_BIT];
      end else if (avs_address_i == mrivc_pkg::REG_LOAD_ADDR) begin
        load_addr_next = avs_writedata_i[mrivc_pkg::MEM_AW-1:0];
      end else if (avs_address_i == mrivc_pkg::REG_LOAD_DATA) begin
        load_addr_next = load_addr_reg + 1'b1;
      end
    end
    if (avs_read_i && !ack_reg) begin
      rdata_next = 32'h0000_0000;
      if (avs_address_i == mrivc_pkg::REG_CTRL) begin
        rdata_next[mrivc_pkg::CTRL_ENABLE_BIT] = enable_reg;
      end else if (avs_address_i == mrivc_pkg::REG_STATUS) begin
        rdata_next[mrivc_pkg::STS_BUSY_BIT] = (state_reg != ST_IDLE);
        rdata_next[mrivc_pkg::STS_INSTALL_BIT] = (state_reg == ST_INSTALL);
        rdata_next[mrivc_pkg::STS_IMG_VALID_BIT] = img_valid_reg;
        rdata_next[mrivc_pkg::STS_IMG_KNOWN_BIT] = img_known_reg;
      end else if (avs_address_i == mrivc_pkg::REG_LOAD_ADDR) begin
        rdata_next[mrivc_pkg::MEM_AW-1:0] = load_addr_reg;
      end else if (avs_address_i == mrivc_pkg::REG_LOAD_DATA) begin
        rdata_next[7:0] = mem[load_addr_reg];
      end else if (avs_address_i == mrivc_pkg::REG_CMD_COUNT) begin
        rdata_next[15:0] = cmd_cnt_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      enable_reg <= mrivc_pkg::CTRL_ENABLE_RESET;
      load_addr_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      enable_reg <= enable_next;
      load_addr_reg <= load_addr_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[load_addr_reg] <= avs_writedata_i[7:0];
    end
  end

  assign avs_readdata_o = rdata_reg;

  // ************************************************************
  // Command engine
  // ************************************************************
  mrivc_pkg::mrivc_rsp_t rsp_reg, rsp_next;
  logic unicast_reg, unicast_next;
  logic install_req_reg, install_req_next;
  logic [15:0] idx_reg, idx_next;
  logic [31:0] tmr_reg, tmr_next;
  logic chk_start_reg, chk_start_next;
  logic install_pulse_reg, install_pulse_next;
  logic [7:0] pay_data_reg, pay_data_next;
  logic rd_error;
  logic [16:0] rd_end;
  logic [mrivc_pkg::MEM_AW-1:0] pay_addr;
  logic take;

  assign take = req_valid_i && req_ready_o;
  assign rd_end = 17'(req_i.byte_offset_field) + 17'(req_i.byte_count_field);
  // Out of range reads are refused rather than wrapped into the next block
  assign rd_error = (req_i.block_index_field >= 16'(mrivc_pkg::NUM_BLOCKS))
                 || (rd_end > 17'(mrivc_pkg::BLOCK_SIZE));
  assign pay_addr = mrivc_pkg::MEM_AW'(32'(rsp_reg.block_index_field) * mrivc_pkg::BLOCK_SIZE
                  + 32'(rsp_reg.byte_offset_field) + 32'(idx_next));

  always_comb begin
    state_next = state_reg;
    rsp_next = rsp_reg;
    unicast_next = unicast_reg;
    install_req_next = install_req_reg;
    idx_next = idx_reg;
    tmr_next = tmr_reg;
    chk_start_next = 1'b0;
    install_pulse_next = 1'b0;
    img_valid_next = img_valid_reg;
    img_known_next = img_known_reg;
    cmd_cnt_next = cmd_cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take && enable_reg) begin
          cmd_cnt_next = cmd_cnt_reg + 16'h0001;
          unicast_next = req_i.unicast;
          rsp_next = '0;
          rsp_next.dst_ep = req_i.src_ep;
          rsp_next.src_ep = req_i.dst_ep;
          if (req_i.command_code_field == mrivc_pkg::CMD_READ) begin
            rsp_next.command_code_field = mrivc_pkg::RSP_READ;
            rsp_next.block_index_field = req_i.block_index_field;
            rsp_next.byte_offset_field = req_i.byte_offset_field;
            rsp_next.result_flags_field[mrivc_pkg::STAT_ERR_BIT] = rd_error;
            rsp_next.byte_count_field = rd_error ? 16'h0000 : req_i.byte_count_field;
            state_next = req_i.unicast ? ST_REPLY : ST_IDLE;
          end else if (req_i.command_code_field == mrivc_pkg::CMD_VERIFY
                    || req_i.command_code_field == mrivc_pkg::CMD_VERIFY_INSTALL) begin
            install_req_next = (req_i.command_code_field == mrivc_pkg::CMD_VERIFY_INSTALL);
            chk_start_next = 1'b1;
            state_next = ST_VERIFY;
          end
        end
      end
      ST_VERIFY: begin
        if (chk_done) begin
          img_valid_next = chk_valid;
          img_known_next = 1'b1;
          if (install_req_reg && chk_valid) begin
            tmr_next = 32'h0000_0000;
            state_next = ST_INSTALL;
          end else begin
            rsp_next.command_code_field = install_req_reg ? mrivc_pkg::RSP_VERIFY_INSTALL
                                                          : mrivc_pkg::RSP_VERIFY;
            rsp_next.result_flags_field[mrivc_pkg::STAT_ERR_BIT] = !chk_valid;
            state_next = unicast_reg ? ST_REPLY : ST_IDLE;
          end
        end
      end
      ST_REPLY: begin
        if (rsp_ready_i) begin
          idx_next = 16'h0000;
          if (rsp_reg.command_code_field == mrivc_pkg::RSP_READ
              && rsp_reg.byte_count_field != 16'h0000) begin
            state_next = ST_STREAM;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_STREAM: begin
        if (pay_ready_i) begin
          if (idx_reg == rsp_reg.byte_count_field - 16'h0001) begin
            state_next = ST_IDLE;
          end else begin
            idx_next = idx_reg + 16'h0001;
          end
        end
      end
      ST_INSTALL: begin
        // Frames are swallowed here; the reset ends it all anyway
        tmr_next = tmr_reg + 32'h0000_0001;
        if (tmr_reg >= INSTALL_CYCLES - 32'h0000_0001) begin
          install_pulse_next = 1'b1;
          img_known_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    pay_data_next = mem[pay_addr];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      rsp_reg <= '0;
      unicast_reg <= 1'b0;
      install_req_reg <= 1'b0;
      idx_reg <= 16'h0000;
      tmr_reg <= 32'h0000_0000;
      chk_start_reg <= 1'b0;
      install_pulse_reg <= 1'b0;
      img_valid_reg <= 1'b0;
      img_known_reg <= 1'b0;
      cmd_cnt_reg <= 16'h0000;
      pay_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      rsp_reg <= rsp_next;
      unicast_reg <= unicast_next;
      install_req_reg <= install_req_next;
      idx_reg <= idx_next;
      tmr_reg <= tmr_next;
      chk_start_reg <= chk_start_next;
      install_pulse_reg <= install_pulse_next;
      img_valid_reg <= img_valid_next;
      img_known_reg <= img_known_next;
      cmd_cnt_reg <= cmd_cnt_next;
      pay_data_reg <= pay_data_next;
    end
  end

  mrivc_img_check u_img_check (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(chk_start_reg),
    .rd_data_i(mem[chk_addr]),
    .rd_addr_o(chk_addr),
    .done_o(chk_done),
    .valid_o(chk_valid)
  );

  assign req_ready_o = (state_reg == ST_IDLE) || (state_reg == ST_INSTALL);
  assign rsp_valid_o = (state_reg == ST_REPLY);
  assign rsp_o = rsp_reg;
  assign pay_valid_o = (state_reg == ST_STREAM);
  assign pay_data_o = pay_data_reg;
  assign pay_last_o = (state_reg == ST_STREAM) && (idx_reg == rsp_reg.byte_count_field - 16'h0001);
  assign install_reset_o = install_pulse_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_READ_ECHO: assert property (
    (state_reg == ST_IDLE && req_valid_i && enable_reg && req_i.unicast
     && req_i.command_code_field == mrivc_pkg::CMD_READ)
    |=> rsp_valid_o && rsp_o.command_code_field == mrivc_pkg::RSP_READ
        && rsp_o.block_index_field == $past(req_i.block_index_field)
        && rsp_o.byte_offset_field == $past(req_i.byte_offset_field)
        && rsp_o.dst_ep == $past(req_i.src_ep))
    else $error("read reply fields do not match the request");
  AST_READ_ERR: assert property (
    (state_reg == ST_IDLE && req_valid_i && enable_reg && rd_error
     && req_i.command_code_field == mrivc_pkg::CMD_READ)
    |=> rsp_o.result_flags_field == 8'h01 && rsp_o.byte_count_field == 16'h0000)
    else $error("bad read range not flagged as error");
  AST_READ_OK: assert property (
    (state_reg == ST_IDLE && req_valid_i && enable_reg && !rd_error
     && req_i.command_code_field == mrivc_pkg::CMD_READ)
    |=> rsp_o.result_flags_field == 8'h00 && rsp_o.byte_count_field == $past(req_i.byte_count_field))
    else $error("good read reply has wrong status or count");
  AST_IMG_ZERO: assert property (
    (rsp_valid_o && rsp_o.command_code_field != mrivc_pkg::RSP_READ)
    |-> rsp_o.block_index_field == 16'h0000 && rsp_o.byte_offset_field == 16'h0000
        && rsp_o.byte_count_field == 16'h0000)
    else $error("image reply fields not zero");
  AST_VERIFY_STATUS: assert property (
    (rsp_valid_o && rsp_o.command_code_field == mrivc_pkg::RSP_VERIFY)
    |-> rsp_o.result_flags_field == {7'h00, !img_valid_reg})
    else $error("verify status does not reflect image validity");
  AST_INSTALL_ONLY_BAD: assert property (
    (rsp_valid_o && rsp_o.command_code_field == mrivc_pkg::RSP_VERIFY_INSTALL)
    |-> rsp_o.result_flags_field == 8'h01 && !img_valid_reg)
    else $error("install reply sent for a valid image");
  AST_INSTALL_ENTRY: assert property (
    (state_reg == ST_VERIFY && chk_done && chk_valid && install_req_reg)
    |=> state_reg == ST_INSTALL ##1 tmr_reg == 32'h0000_0001)
    else $error("valid image did not start install");
  AST_INSTALL_QUIET: assert property (
    (state_reg == ST_INSTALL) |-> !rsp_valid_o && !pay_valid_o && req_ready_o
        && !install_reset_o)
    else $error("traffic answered during install");
  AST_INSTALL_END: assert property (
    $rose(install_reset_o) |-> $past(state_reg) == ST_INSTALL && state_reg == ST_IDLE
        && $past(tmr_reg) >= INSTALL_CYCLES - 32'h0000_0001)
    else $error("install reset out of sequence");
  AST_STREAM_END: assert property (
    (pay_valid_o && pay_ready_i && pay_last_o) |=> !pay_valid_o && state_reg == ST_IDLE)
    else $error("payload ran past the byte count");

endmodule // mrivc_cmd

`default_nettype wire

//--- sim/mrivc_node_model.sv
// Purpose: Requesting node that takes replies and payload bytes
// Assumes: Same clock as the handler
// Notes: Stalls at random while slow_i is high
`timescale 1ns/10ps
`default_nettype none
module mrivc_node_model (
  input wire logic clk_i,
  input wire logic slow_i,
  output logic rsp_ready_o,
  output logic pay_ready_o
);
  int seed = 32'h51;
  // Stalls prove that reply and payload hold until taken
  always @(posedge clk_i) begin
    rsp_ready_o <= !slow_i || ($random(seed) % 2 == 0);
    pay_ready_o <= !slow_i || ($random(seed) % 2 == 0);
  end
endmodule // mrivc_node_model
`default_nettype wire

//--- sim/mrivc_cmd_test.sv
// Purpose: Self-checking bench for the flash read and image check handler
// Assumes: Requests are issued one at a time
// Notes: Install time shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
module mrivc_cmd_test;
  localparam logic [31:0] INST = 32'h14;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, rq_v = 0, slow = 0;
  logic [7:0] addr = 0;
  logic [3:0] be = 4'h1;
  logic [31:0] wdata = 0, rdata, q;
  logic wait_r, rq_rdy, rsp_v, rsp_rdy, pay_v, pay_l, pay_rdy, inst_rst;
  logic [7:0] pay_d;
  mrivc_pkg::mrivc_req_t rq = '0;
  mrivc_pkg::mrivc_rsp_t rsp, cap;
  logic [7:0] mem [512];
  logic [7:0] got [$];
  int errors = 0, total_checks = 0, cyc = 0, n_rsp = 0, n_rst = 0, n0, lastn, t0, k;
  int seed = 32'h8db9;
  always #2 clk = ~clk;
  mrivc_cmd #(.INSTALL_CYCLES(INST)) dut_u (.clk_i(clk), .rst_n_i(rst_n),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
    .req_valid_i(rq_v), .req_i(rq), .req_ready_o(rq_rdy), .rsp_valid_o(rsp_v),
    .rsp_o(rsp), .rsp_ready_i(rsp_rdy), .pay_valid_o(pay_v), .pay_data_o(pay_d),
    .pay_last_o(pay_l), .pay_ready_i(pay_rdy), .install_reset_o(inst_rst));
  mrivc_node_model node_u (.clk_i(clk), .slow_i(slow), .rsp_ready_o(rsp_rdy),
    .pay_ready_o(pay_rdy));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rsp_v && rsp_rdy) begin
      cap <= rsp;
      n_rsp <= n_rsp + 1;
    end
    if (pay_v && pay_rdy) begin
      got.push_back(pay_d);
      if (pay_l) lastn = got.size();
    end
    if (inst_rst) n_rst <= n_rst + 1;
    if (cyc == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_r !== 1'b0);
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask
  task automatic poke(input int i);
    bus(1, mrivc_pkg::REG_LOAD_ADDR, i);
    bus(1, mrivc_pkg::REG_LOAD_DATA, {24'h0, mem[i]});
  endtask
  function automatic logic img_ok();
    logic [7:0] s = 0;
    foreach (mem[i]) s += mem[i];
    return s == 0 && mem[0] != 8'hff;
  endfunction
  task automatic send(input logic [7:0] c, input logic [15:0] b, o, n, input logic u);
    n0 = n_rsp;
    lastn = 0;
    got.delete();
    @(posedge clk);
    rq <= '{u, 8'($random(seed)), 8'($random(seed)), c, 8'h00, b, o, n};
    rq_v <= 1;
    do @(posedge clk); while (rq_rdy !== 1'b1);
    rq_v <= 0;
  endtask
  task automatic reply(input logic [7:0] c, f, input logic [15:0] b, o, n);
    while (n_rsp == n0) @(posedge clk);
    repeat (1000) if (got.size() < n) @(posedge clk);
    repeat (3) @(posedge clk);
    check(cap, {rq.src_ep, rq.dst_ep, c, f, b, o, n});
    check(got.size(), n);
    check(lastn, n);
  endtask
  task automatic do_read(input logic [15:0] b, o, n);
    logic e;
    e = b > 3 || o + n > 128;
    send(mrivc_pkg::CMD_READ, b, o, n, 1);
    reply(mrivc_pkg::RSP_READ, {7'h0, e}, b, o, e ? 16'h0 : n);
    foreach (got[i]) check(got[i], mem[b * 128 + o + i]);
  endtask
  task automatic do_check(input logic [7:0] c, r);
    send(c, 0, 0, 0, 1);
    reply(r, {7'h0, !img_ok()}, 0, 0, 0);
    bus(0, mrivc_pkg::REG_STATUS, 0);
    check(q[3:0], {1'b1, img_ok(), 2'b00});
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    bus(0, mrivc_pkg::REG_CTRL, 0);
    check(q[0], 1);
    bus(0, 8'h40, 0);
    check(q, 0);
    foreach (mem[i]) mem[i] = 8'($random(seed));
    mem[0] = 8'h5a;
    mem[511] = 0;
    mem[511] = -img_sum();
    bus(1, mrivc_pkg::REG_LOAD_ADDR, 0);
    foreach (mem[i]) bus(1, mrivc_pkg::REG_LOAD_DATA, {24'h0, mem[i]});
    $display("test load done");
    do_read(3, 0, 128);
    do_read(2, 127, 1);
    do_read(0, 5, 0);
    do_read(1, 100, 29);
    do_read(4, 0, 1);
    for (int i = 0; i < 12; i++) begin
      slow <= i[0];
      k = {$random(seed)} % 128;
      do_read({$random(seed)} % 4, k, {$random(seed)} % (129 - k));
    end
    send(mrivc_pkg::CMD_READ, 0, 0, 4, 0);
    repeat (20) @(posedge clk);
    check(n_rsp, n0);
    $display("test read done");
    do_check(mrivc_pkg::CMD_VERIFY, mrivc_pkg::RSP_VERIFY);
    mem[7] = mem[7] + 1;
    poke(7);
    do_check(mrivc_pkg::CMD_VERIFY, mrivc_pkg::RSP_VERIFY);
    do_check(mrivc_pkg::CMD_VERIFY_INSTALL, mrivc_pkg::RSP_VERIFY_INSTALL);
    $display("test verify done");
    mem[7] = mem[7] - 1;
    poke(7);
    k = n_rsp;
    t0 = n_rst;
    send(mrivc_pkg::CMD_VERIFY_INSTALL, 0, 0, 0, 1);
    q = 0;
    while (!q[mrivc_pkg::STS_INSTALL_BIT]) bus(0, mrivc_pkg::REG_STATUS, 0);
    send(mrivc_pkg::CMD_READ, 0, 0, 1, 1);
    while (n_rst == t0) @(posedge clk);
    repeat (30) @(posedge clk);
    check(n_rst, t0 + 1);
    check(n_rsp, k);
    $display("test install done");
    tally_and_finish();
  end
  function automatic logic [7:0] img_sum();
    logic [7:0] s = 0;
    foreach (mem[i]) s += mem[i];
    return s;
  endfunction
endmodule // mrivc_cmd_test
`default_nettype wire
